// [analog_front.sv]
/*
  behavioural analog front end: selector, sample-and-hold, comparator, rc oscillator.
  assumes the eight source levels arrive as packed 8-bit codes from the bench.
*/
`timescale 1ns/1ps

module analog_front (
  input wire aclk,
  input wire [63:0] levels,
  input wire [2:0] input_select,
  input wire sample_switch,
  input wire [7:0] dac_code,
  input wire rc_osc_enable,
  output wire comparator_in,
  output logic rc_osc_clk
);
  logic [7:0] held = 8'h00;
  // track the selected source while the switch is closed, hold after
  always @(posedge aclk) begin
    if (sample_switch) begin
      held <= levels[input_select*8 +: 8];
    end
  end
  // ideal comparator; full-scale code ff sits at or above every trial
  assign comparator_in = held >= dac_code;
  // oscillator faster than real to keep runs short; stands low when off
  initial begin
    rc_osc_clk = 1'b0;
    forever begin
      #13;
      rc_osc_clk = rc_osc_enable ? ~rc_osc_clk : 1'b0;
    end
  end
endmodule

// [pin_sync.v]
/*
  two-flop synchroniser for a group of asynchronous level inputs.
  assumes the inputs are independent levels; no bus coherence is implied.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------------
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // first stage feeds only the second, so metastability never reaches logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

// [sar_adc_control.v]
/*
  control logic of an 8-bit successive-approximation converter with an
  eight-way input selector, reached over axi4-lite.
  assumes the analog front end outside: a comparator whose output is high
  while the held input is at or above the dac level, and a free-running rc
  oscillator whose clock arrives as a plain pin level.
*/
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sar_adc_map.vh"

module sar_adc_control (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire comparator_in,
  input wire rc_osc_clk,
  input wire stop_mode,
  output wire [2:0] input_select,
  output wire sample_switch,
  output wire [7:0] dac_code,
  output wire comparator_enable,
  output wire rc_osc_enable,
  output wire irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function [11:0] byte_addr;
    input [9:0] idx;
    begin
      byte_addr = {idx, 2'b00};
    end
  endfunction

  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  localparam ST_OFF = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_q;
  reg rc_sel_q;
  reg power_q;
  reg done_q;
  reg [2:0] sel_q;
  reg [7:0] result_q;
  reg cpu_div_q;
  reg [7:0] trial_q;
  reg [2:0] bit_q;
  reg [4:0] tick_cnt_q;
  reg [3:0] sample_cnt_q;
  reg sample_q;
  reg rc_prev_q;
  reg irq_status_q;
  reg irq_enable_q;
  reg irq_q;
  reg awready_q;
  reg wready_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [11:0] waddr_q;
  reg [31:0] wdata_q;
  reg wlane0_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire cmp_s;
  wire rc_s;
  pin_sync #(.WIDTH(2)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({comparator_in, rc_osc_clk}),
    .sync_out({cmp_s, rc_s})
  );

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_csr = do_write && wlane0_q && (waddr_q == byte_addr(`CSR_IDX));
  wire wr_clear = do_write && wlane0_q && (waddr_q == byte_addr(`IRQ_CLEAR_IDX));
  wire wr_enable = do_write && wlane0_q && (waddr_q == byte_addr(`IRQ_ENABLE_IDX));
  wire ar_take = s_axi_arvalid && arready_q;
  wire rd_result = ar_take && (s_axi_araddr == byte_addr(`RESULT_IDX));

  // write is known only when the address is one of the mapped words
  wire waddr_ok = (waddr_q == byte_addr(`RESULT_IDX)) ||
                  (waddr_q == byte_addr(`CSR_IDX)) ||
                  (waddr_q == byte_addr(`IRQ_STATUS_IDX)) ||
                  (waddr_q == byte_addr(`IRQ_CLEAR_IDX)) ||
                  (waddr_q == byte_addr(`IRQ_ENABLE_IDX));

  // ----------------------------------------------------------------------
  // conversion clock selection
  // ----------------------------------------------------------------------
  // rc edges pass the synchroniser, so at most one tick per two bus cycles; the
  // cpu clock is halved since the synced comparator needs three cycles a bit
  wire rc_edge = rc_s && !rc_prev_q;
  wire active = power_q && !stop_mode;
  wire conv_tick = rc_sel_q ? rc_edge : cpu_div_q;
  wire last_tick = conv_tick && (tick_cnt_q == `LAST_TICK);
  wire decide_tick = conv_tick && (tick_cnt_q > `FIRST_TRIAL_TICK) &&
                     (tick_cnt_q[0] == 1'b0);
  wire trial_tick = conv_tick && (tick_cnt_q == `FIRST_TRIAL_TICK);
  wire finish = (state_q == ST_RUN) && active && last_tick && !wr_csr;

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  // a control write or stop always wins over a finishing conversion
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_OFF;
      cpu_div_q <= 1'b0;
      trial_q <= 8'h00;
      bit_q <= 3'h7;
      tick_cnt_q <= 5'h00;
      sample_cnt_q <= 4'h0;
      sample_q <= 1'b0;
      rc_prev_q <= 1'b0;
      result_q <= `RESULT_RESET;
    end else begin
      rc_prev_q <= rc_s;
      cpu_div_q <= !cpu_div_q;
      if (!active || wr_csr) begin
        // restart fresh: next run begins with a new sample
        state_q <= active ? ST_RUN : ST_OFF;
        trial_q <= 8'h00;
        bit_q <= 3'h7;
        tick_cnt_q <= 5'h00;
        sample_cnt_q <= 4'h0;
        sample_q <= active;
      end else begin
        case (state_q)
          ST_OFF: begin
            state_q <= ST_RUN;
            sample_q <= 1'b1;
          end
          ST_RUN: begin
            // sampling window counted in bus cycles whatever the clock
            if (sample_q) begin
              if (sample_cnt_q == `SAMPLE_CYCLES - 4'd1) begin
                sample_q <= 1'b0;
              end
              sample_cnt_q <= sample_cnt_q + 4'd1;
            end
            if (conv_tick) begin
              tick_cnt_q <= tick_cnt_q + 5'd1;
            end
            if (trial_tick) begin
              trial_q <= 8'h80;
            end else if (decide_tick && !sample_q) begin
              // keep the trial bit only when the input is not below it
              if (!cmp_s) begin
                trial_q[bit_q] <= 1'b0;
              end
              if (bit_q != 3'h0) begin
                trial_q[bit_q - 3'd1] <= 1'b1;
                bit_q <= bit_q - 3'd1;
              end
            end
            if (last_tick) begin
              // full scale needs no overflow bit: all trials kept gives ff
              result_q <= trial_q;
              trial_q <= 8'h00;
              bit_q <= 3'h7;
              tick_cnt_q <= 5'h00;
              sample_q <= 1'b1;
              sample_cnt_q <= 4'h0;
            end
          end
          default: begin
            state_q <= ST_OFF;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------------
  // completion sets done even if a result read lands in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_sel_q <= 1'b0;
      power_q <= 1'b0;
      done_q <= 1'b0;
      sel_q <= `CSR_SEL_RESET;
    end else begin
      if (wr_csr) begin
        rc_sel_q <= wdata_q[`CSR_RC_SEL_BIT];
        power_q <= wdata_q[`CSR_POWER_BIT];
        sel_q <= wdata_q[`CSR_SEL_MSB:`CSR_SEL_LSB];
      end
      if (finish) begin
        done_q <= 1'b1;
      end else if (rd_result || wr_csr) begin
        done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, clear and enable
  // ----------------------------------------------------------------------
  wire irq_status_d = finish || (irq_status_q && !(wr_clear && wdata_q[`IRQ_DONE_BIT]));
  wire irq_enable_d = wr_enable ? wdata_q[`IRQ_DONE_BIT] : irq_enable_q;

  // the line is registered from next values so it follows status at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= 1'b0;
      irq_enable_q <= `IRQ_ENABLE_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      irq_q <= irq_status_d && irq_enable_d;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  // address and data are taken in either order; both ready lines reopen
  // only after the response is accepted, so one write is in flight at most
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wlane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (!aw_hold_q && !bvalid_q && !awready_q) begin
        awready_q <= 1'b1;
      end
      if (!w_hold_q && !bvalid_q && !wready_q) begin
        wready_q <= 1'b1;
      end
      if (aw_take) begin
        awready_q <= 1'b0;
        aw_hold_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wready_q <= 1'b0;
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wlane0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= waddr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else begin
      if (!rvalid_q && !arready_q) begin
        arready_q <= 1'b1;
      end
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= `RESP_OKAY;
        if (s_axi_araddr == byte_addr(`RESULT_IDX)) begin
          rdata_q <= {24'h000000, result_q};
        end else if (s_axi_araddr == byte_addr(`CSR_IDX)) begin
          rdata_q <= {24'h000000, done_q, rc_sel_q, power_q, 2'b00, sel_q};
        end else if (s_axi_araddr == byte_addr(`IRQ_STATUS_IDX)) begin
          rdata_q <= {31'h00000000, irq_status_q};
        end else if (s_axi_araddr == byte_addr(`IRQ_ENABLE_IDX)) begin
          rdata_q <= {31'h00000000, irq_enable_q};
        end else if (s_axi_araddr == byte_addr(`IRQ_CLEAR_IDX)) begin
          rdata_q <= 32'h00000000; // write-only word reads as zero
        end else begin
          rdata_q <= 32'h00000000;
          rresp_q <= `RESP_SLVERR;
        end
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign input_select = sel_q;
  assign sample_switch = sample_q;
  assign dac_code = trial_q;
  assign comparator_enable = state_q;
  assign rc_osc_enable = rc_sel_q;
  assign irq = irq_q;

endmodule

// [sar_adc_control_chk.sv]
/*
  port checker for the converter control block: bus handshakes and converter pins.
  assumes it is bound onto the control module; one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "sar_adc_map.vh"

module sar_adc_control_chk (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire stop_mode,
  input wire sample_switch,
  input wire comparator_enable
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers stand until the master takes them
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  ar_refuse_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read accepted");
  unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0FC
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  // a normal end of sampling follows twelve closed cycles
  sample_len_a: assert property ($fell(sample_switch) && comparator_enable
    |-> $past(sample_switch, 12)) else $error("sample window short");
  stop_off_a: assert property (stop_mode |=> !comparator_enable)
    else $error("comparator still on in stop");
  stop_idle_a: assert property (stop_mode ##1 stop_mode |-> !sample_switch)
    else $error("sampling during stop");
endmodule

// [sar_adc_control_tb.sv]
/*
  self-checking bench: axi4-lite master tasks, integer model of the sources.
  assumes the analog front model and the port checker in the same folder.
*/
`timescale 1ns/1ps
`include "sar_adc_map.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module sar_adc_control_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [1:0] r;
  logic [63:0] levels;
  wire awready, wready, bvalid, arready, rvalid, comp, rc_clk, sw, cmp_en, rc_en, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] sel;
  wire [7:0] dac;
  int errors, num_checks, cyc, seed;
  int lvl [0:7];

  sar_adc_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .comparator_in(comp), .rc_osc_clk(rc_clk), .stop_mode(stop_mode),
    .input_select(sel), .sample_switch(sw), .dac_code(dac), .comparator_enable(cmp_en),
    .rc_osc_enable(rc_en), .irq(irq));
  analog_front fe (.aclk(aclk), .levels(levels), .input_select(sel), .sample_switch(sw),
    .dac_code(dac), .rc_osc_enable(rc_en), .comparator_in(comp), .rc_osc_clk(rc_clk));

  // ----------------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // bus tasks: handshakes judged at the negedge, since readys change only at posedges
  // ----------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tk;
    @(posedge aclk);
    tk = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tk) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, tk;
    @(posedge aclk);
    tk = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tk) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tk = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // let registered pins land before looking at them
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask
  // poll the flag; the rc clock is unrelated, so no cycle counting
  task automatic check_result(input int ch);
    int n;
    n = 0;
    d = 32'h0;
    while (d[7] !== 1'b1 && n < 300) begin
      rd(12'h044);
      n++;
    end
    `CHK(d[7], 1'b1)
    rd(12'h040);
    `CHK(d, 32'(lvl[ch]))
    rd(12'h044);
    `CHK(d[7], 1'b0)
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h6faf6858;
    {awvalid, wvalid, bready, arvalid, rready, stop_mode, aresetn} = 7'h00;
    {awaddr, araddr, wdata} = 56'h0;
    for (int i = 0; i < 8; i++) lvl[i] = $random(seed) & 255;
    lvl[4] = 255;
    lvl[5] = 128;
    lvl[6] = 0;
    for (int i = 0; i < 8; i++) levels[i*8 +: 8] = lvl[i][7:0];
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(12'h044);
    `CHK(d, 32'h0)
    rd(12'h050);
    `CHK(d, 32'h0)
    rd(12'h0FC);
    `CHK(r, `RESP_SLVERR)
    wr(12'h0FC, 32'h1);
    `CHK(r, `RESP_SLVERR)
    rd(12'h04C);
    `CHK(d, 32'h0)
    // every source code, each write restarting with done cleared
    for (int ch = 0; ch < 8; ch++) begin
      wr(12'h044, 32'h20 | ch);
      rd(12'h044);
      `CHK(d, 32'h20 | ch)
      `CHK(sel, 3'(ch))
      check_result(ch);
    end
    check_result(7);
    wr(12'h040, 32'h5A);
    `CHK(r, `RESP_OKAY)
    check_result(7);
    `CHK(irq, 1'b0)
    wr(12'h050, 32'h1);
    settle();
    `CHK(irq, 1'b1)
    rd(12'h048);
    `CHK(d, 32'h1)
    // turn off first so no new event races the clear
    wr(12'h044, 32'h0);
    wr(12'h04C, 32'h1);
    settle();
    `CHK(cmp_en, 1'b0)
    `CHK(irq, 1'b0)
    rd(12'h048);
    `CHK(d, 32'h0)
    wr(12'h044, 32'h25);
    repeat (20) @(posedge aclk);
    stop_mode <= 1'b1;
    settle();
    `CHK(cmp_en, 1'b0)
    @(posedge aclk);
    stop_mode <= 1'b0;
    check_result(5);
    wr(12'h044, 32'h40);
    settle();
    `CHK({rc_en, cmp_en}, 2'h2)
    wr(12'h044, 32'h63);
    check_result(3);
    `CHK(rc_en, 1'b1)
    final_report();
  end
endmodule

bind sar_adc_control sar_adc_control_chk chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .stop_mode(stop_mode),
  .sample_switch(sample_switch), .comparator_enable(comparator_enable));

// [sar_adc_map.vh]
/*
  register indices, field positions, reset values and timing counts of the
  successive-approximation converter control block.
  assumes a 32-bit register bus whose byte address is four times the index.
*/
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RESULT_IDX 10'h010
`define CSR_IDX 10'h011
`define IRQ_STATUS_IDX 10'h012
`define IRQ_CLEAR_IDX 10'h013
`define IRQ_ENABLE_IDX 10'h014

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define CSR_DONE_BIT 7
`define CSR_RC_SEL_BIT 6
`define CSR_POWER_BIT 5
`define CSR_SEL_MSB 2
`define CSR_SEL_LSB 0
`define IRQ_DONE_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSR_SEL_RESET 3'h0
`define RESULT_RESET 8'h00
`define IRQ_ENABLE_RESET 1'h0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define CONV_TICKS 6'd32
`define SAMPLE_CYCLES 4'd12
`define FIRST_TRIAL_TICK 5'd14
`define LAST_TICK 5'd31

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
